// ### rtl/gpi_interrupt_event_config.sv
// Top of the input polarity, event logging and interrupt enable configuration block
// Function
// - Polarity 0 sets status on low pin, 1 sets status on high pin.
// - First bank bits 0..5 serve inputs 1..6 on row pins 0..5.
// - Second bank bits 0..4 serve inputs 7..11 on row pins 6..10.
// - Bit 5 of first bank works only on six-row variant, else reserved.
// - Event-enable 1 logs input activity into the event queue, 0 logs nothing.
// - Logged input activity raises the event interrupt flag like key events.
// - Logged inputs never feed the summary input interrupt.
// - Logged input events qualify for unlock logic like other queue events.
// - Enabled input with event logging off, status set and condition met asserts summary bit.
// - Disabled input status never affects the summary bit.
// - First-bank interrupt enables in bits 0..5, bits 7 and 6 reserved.
`timescale 1ns/1ps
module gpi_interrupt_event_config #(
    parameter bit SIXTH_ROW_PRESENT = 1'b1
) (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // Register port from the serial bus front end
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regWdata,
    output logic      [7:0]  regRdata,
    output logic             regHit,
    // Row pins
    input  wire logic [10:0] rowPin,
    // Status clears from the interrupt status register
    input  wire logic [10:0] statusClear,
    // Status toward the rest of the device
    output logic      [10:0] irqStatus,
    output logic             summaryInputIrq,
    output logic             eventIrqSet,
    output logic             unlockEvent,
    // Event queue write port
    output logic             queueWrite,
    output logic      [3:0]  queueCode
);
    logic [7:0]  polA_q;
    logic [7:0]  polB_q;
    logic [7:0]  evtA_q;
    logic [7:0]  evtB_q;
    logic [7:0]  irqA_q;
    logic [7:0]  irqB_q;
    logic [10:0] polAll;
    logic [10:0] evtAll;
    logic [10:0] irqAll;
    logic [10:0] sliceStatus;
    logic [10:0] sliceSummary;
    logic [10:0] sliceEvent;
    logic [10:0] pendEvt_q;
    logic [10:0] pendEvt_d;
    logic [10:0] pickOneHot;
    logic [3:0]  pickCode;
    logic        pickValid;
    logic [7:0]  maskA;
    logic [7:0]  rdMux;
    logic        hit;
    logic        wPolA;
    logic        wPolB;
    logic        wEvtA;
    logic        wEvtB;
    logic        wIrqA;
    logic        wIrqB;
    logic        selPolA;
    logic        selPolB;
    logic        selEvtA;
    logic        selEvtB;
    logic        selIrqA;
    logic        selIrqB;
    logic [7:0]  wdataA;
    logic [7:0]  wdataB;

    // Without the sixth row pin bit 5 is reserved in every first-bank register
    assign maskA = SIXTH_ROW_PRESENT ? gpi_cfg_pkg::MASK_BANK_A : gpi_cfg_pkg::MASK_BANK_A_V5;

    // Address decode, one select per register
    assign selPolA = (regAddr == gpi_cfg_pkg::OFS_POL_A);
    assign selPolB = (regAddr == gpi_cfg_pkg::OFS_POL_B);
    assign selEvtA = (regAddr == gpi_cfg_pkg::OFS_EVT_A);
    assign selEvtB = (regAddr == gpi_cfg_pkg::OFS_EVT_B);
    assign selIrqA = (regAddr == gpi_cfg_pkg::OFS_IRQ_A);
    assign selIrqB = (regAddr == gpi_cfg_pkg::OFS_IRQ_B);

    assign wPolA = regWrite & selPolA;
    assign wPolB = regWrite & selPolB;
    assign wEvtA = regWrite & selEvtA;
    assign wEvtB = regWrite & selEvtB;
    assign wIrqA = regWrite & selIrqA;
    assign wIrqB = regWrite & selIrqB;

    assign hit = selPolA | selPolB | selEvtA
               | selEvtB | selIrqA | selIrqB;

    // Reserved positions are never stored, so they read back as zero
    assign wdataA = regWdata & maskA;
    assign wdataB = regWdata & gpi_cfg_pkg::MASK_BANK_B;

    always_ff @(posedge mclk) begin
        if (rst) begin
            polA_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wPolA) begin
            polA_q <= wdataA;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            polB_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wPolB) begin
            polB_q <= wdataB;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            evtA_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wEvtA) begin
            evtA_q <= wdataA;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            evtB_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wEvtB) begin
            evtB_q <= wdataB;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqA_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wIrqA) begin
            irqA_q <= wdataA;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqB_q <= gpi_cfg_pkg::RESET_VALUE;
        end else if (clkEn && wIrqB) begin
            irqB_q <= wdataB;
        end
    end

    // Unmapped addresses fall through to zero
    assign rdMux = selPolA ? polA_q :
                   selPolB ? polB_q :
                   selEvtA ? evtA_q :
                   selEvtB ? evtB_q :
                   selIrqA ? irqA_q :
                   selIrqB ? irqB_q : 8'h00;

    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdata <= 8'h00;
            regHit   <= 1'b0;
        end else if (clkEn) begin
            regRdata <= regRead ? rdMux : 8'h00;
            regHit   <= regRead & hit;
        end
    end

    // Input n+1 maps to bit n of bank A, input 7+m to bit m of bank B
    assign polAll = {polB_q[4:0], polA_q[5:0]};
    assign evtAll = {evtB_q[4:0], evtA_q[5:0]};
    assign irqAll = {irqB_q[4:0], irqA_q[5:0]};

    // Each slice synchronises its own pin, so slice status lags the pin by three edges and irqStatus by four
    for (genvar i = 0; i < gpi_cfg_pkg::NUM_INPUTS; i++) begin : g_slice
        gpi_input_slice u_slice (
            .mclk        (mclk),
            .rst         (rst),
            .clkEn       (clkEn),
            .rowPin      (rowPin[i]),
            .polaritySel (polAll[i]),
            .eventLogEn  (evtAll[i]),
            .irqEn       (irqAll[i]),
            .statusClear (statusClear[i]),
            .irqStatus   (sliceStatus[i]),
            .summaryTerm (sliceSummary[i]),
            .eventPulse  (sliceEvent[i])
        );
    end

    // Simultaneous events queue one per cycle, lowest input first
    assign pickOneHot = pendEvt_q & (~pendEvt_q + 11'h001);
    assign pickValid  = |pendEvt_q;
    assign pendEvt_d  = (pendEvt_q & ~pickOneHot) | sliceEvent;

    always_comb begin
        pickCode = 4'h0;
        for (int k = gpi_cfg_pkg::NUM_INPUTS - 1; k >= 0; k--) begin
            if (pickOneHot[k]) pickCode = gpi_cfg_pkg::EVENT_CODE_BASE + 4'(k);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pendEvt_q       <= 11'h000;
            queueWrite      <= 1'b0;
            queueCode       <= 4'h0;
            eventIrqSet     <= 1'b0;
            unlockEvent     <= 1'b0;
            irqStatus       <= 11'h000;
            summaryInputIrq <= 1'b0;
        end else if (clkEn) begin
            pendEvt_q       <= pendEvt_d;
            queueWrite      <= pickValid;
            queueCode       <= pickCode;
            eventIrqSet     <= pickValid;
            unlockEvent     <= pickValid;
            irqStatus       <= sliceStatus;
            summaryInputIrq <= |sliceSummary;
        end
    end
endmodule : gpi_interrupt_event_config

// ### rtl/gpi_cfg_pkg.sv
// Package with register map, field layout and reset values of the input configuration block
package gpi_cfg_pkg;
    localparam int          NUM_INPUTS      = 11;
    localparam int          BANK_A_WIDTH    = 6;
    localparam int          BANK_B_WIDTH    = 5;
    localparam int          BANK_B_BASE     = 6;
    localparam logic [7:0]  OFS_POL_A       = 8'h1B;
    localparam logic [7:0]  OFS_POL_B       = 8'h1C;
    localparam logic [7:0]  OFS_EVT_A       = 8'h1D;
    localparam logic [7:0]  OFS_EVT_B       = 8'h1E;
    localparam logic [7:0]  OFS_IRQ_A       = 8'h1F;
    localparam logic [7:0]  OFS_IRQ_B       = 8'h20;
    localparam logic [7:0]  MASK_BANK_A     = 8'h3F;
    localparam logic [7:0]  MASK_BANK_A_V5  = 8'h1F;
    localparam logic [7:0]  MASK_BANK_B     = 8'h1F;
    localparam logic [7:0]  RESET_VALUE     = 8'h00;
    localparam int          SUMMARY_BIT     = 1;
    localparam logic [7:0]  OFS_STATUS      = 8'h01;
    localparam logic [3:0]  EVENT_CODE_BASE = 4'h1;
endpackage : gpi_cfg_pkg

// ### rtl/gpi_input_slice.sv
// One general-purpose input: pin synchroniser, status, queue event and summary contribution
`timescale 1ns/1ps
module gpi_input_slice (
    // Clock and control
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic clkEn,
    // Pin and configuration
    input  wire logic rowPin,
    input  wire logic polaritySel,
    input  wire logic eventLogEn,
    input  wire logic irqEn,
    input  wire logic statusClear,
    // Results
    output logic      irqStatus,
    output logic      summaryTerm,
    output logic      eventPulse
);
    logic syncA_q;
    logic syncB_q;
    logic prev_q;
    logic status_q;
    logic status_d;
    logic condMet;
    logic activity;

    // Polarity 0 means active low, 1 active high
    assign condMet  = rowPin_sync_match(syncB_q, polaritySel);
    assign activity = syncB_q ^ prev_q;
    // A pending condition beats a clear in the same cycle
    assign status_d = condMet ? 1'b1 : (statusClear ? 1'b0 : status_q);

    function automatic logic rowPin_sync_match(input logic lvl, input logic pol);
        rowPin_sync_match = (lvl == pol);
    endfunction : rowPin_sync_match

    always_ff @(posedge mclk) begin
        if (rst) begin
            syncA_q   <= 1'b0;
            syncB_q   <= 1'b0;
            prev_q    <= 1'b0;
            status_q  <= 1'b0;
            eventPulse <= 1'b0;
        end else if (clkEn) begin
            syncA_q   <= rowPin;
            syncB_q   <= syncA_q;
            prev_q    <= syncB_q;
            status_q  <= status_d;
            eventPulse <= activity & eventLogEn;
        end
    end

    assign irqStatus   = status_q;
    // Logged inputs are kept out of the summary whatever irqEn says
    assign summaryTerm = irqEn & ~eventLogEn & status_q & condMet;
endmodule : gpi_input_slice

// ### test/gpi_cfg_assertions.sv
// Port-level checks for the input configuration block
`timescale 1ns/1ps
module gpi_cfg_assertions (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic        regRead,
    input wire logic [7:0]  regRdata,
    input wire logic        regHit,
    // Status and events
    input wire logic [10:0] irqStatus,
    input wire logic        summaryInputIrq,
    input wire logic        eventIrqSet,
    input wire logic        unlockEvent,
    input wire logic        queueWrite,
    input wire logic [3:0]  queueCode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire mapped = (regAddr >= gpi_cfg_pkg::OFS_POL_A) && (regAddr <= gpi_cfg_pkg::OFS_IRQ_B);
    idle_read_zero_a: assert property (!$past(regRead) |-> regRdata == 8'h00)
        else $error("read data not idle");
    hit_cause_a: assert property (regHit |-> $past(regRead && mapped))
        else $error("hit without mapped read");
    unmapped_read_a: assert property ($past(regRead && !mapped) |-> regRdata == 8'h00 && !regHit)
        else $error("unmapped read answered");
    bank_a_reserved_a: assert property ($past(regRead && mapped && regAddr[0]) |-> regRdata[7:6] == 2'b00)
        else $error("bank A reserved bits set");
    bank_b_reserved_a: assert property ($past(regRead && mapped && !regAddr[0]) |-> regRdata[7:5] == 3'b000)
        else $error("bank B reserved bits set");
    event_flags_a: assert property (eventIrqSet == queueWrite && unlockEvent == queueWrite)
        else $error("event flags out of step");
    event_code_a: assert property (queueWrite |-> queueCode inside {[4'h1:4'hB]})
        else $error("bad event code");
    summary_cause_a: assert property (summaryInputIrq |-> (|irqStatus) || $past(|irqStatus))
        else $error("summary without status");
    reset_quiet_a: assert property ($fell(rst) |-> irqStatus == 11'h000 && !queueWrite && !summaryInputIrq)
        else $error("outputs busy after reset");
    cover property (queueWrite);
    cover property (summaryInputIrq);
    cover property ($past(regRead && !mapped));
endmodule : gpi_cfg_assertions

bind gpi_interrupt_event_config gpi_cfg_assertions chk (.mclk(mclk), .rst(rst), .regAddr(regAddr),
    .regRead(regRead), .regRdata(regRdata), .regHit(regHit), .irqStatus(irqStatus),
    .summaryInputIrq(summaryInputIrq), .eventIrqSet(eventIrqSet), .unlockEvent(unlockEvent),
    .queueWrite(queueWrite), .queueCode(queueCode));

// ### test/reg_host.sv
// Host model driving the register port of the block
`timescale 1ns/1ps
module reg_host (
    // Clock
    input  wire logic mclk,
    // Register port
    output logic [7:0] regAddr,
    output logic       regWrite,
    output logic       regRead,
    output logic [7:0] regWdata
);
    initial {regAddr, regWrite, regRead, regWdata} = 18'h00000;
    // Released address and data show the inverse so stale values never pass
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        regAddr <= ~a;
    endtask : rd
endmodule : reg_host

// ### test/gpi_interrupt_event_config_tb_top.sv
// Self-checking bench for the input configuration block
`timescale 1ns/1ps
module gpi_interrupt_event_config_tb_top;
    logic mclk, rst, regWrite, regRead, regHit, summaryInputIrq, eventIrqSet, unlockEvent, queueWrite;
    logic [7:0] regAddr, regWdata, regRdata, lfsr;
    logic [10:0] rowPin, statusClear, irqStatus;
    logic [3:0] queueCode;
    logic rdPend = 1'b0;
    logic [8:0] rq[$];
    logic [3:0] eq[$];
    int nMismatch = 0, comparisons = 0, k, b, pos;
    reg_host host (.mclk(mclk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata));
    gpi_interrupt_event_config #(.SIXTH_ROW_PRESENT(1'b1)) uut (.mclk(mclk), .rst(rst), .clkEn(1'b1),
        .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .regHit(regHit), .rowPin(rowPin), .statusClear(statusClear), .irqStatus(irqStatus),
        .summaryInputIrq(summaryInputIrq), .eventIrqSet(eventIrqSet), .unlockEvent(unlockEvent),
        .queueWrite(queueWrite), .queueCode(queueCode));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task report_and_stop;
        if (nMismatch == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Results are paired with the oldest note as they appear
    always @(posedge mclk) begin
        if (rdPend) chk(16'({regHit, regRdata}), 16'(rq.size() ? rq.pop_front() : 9'h1FF));
        if (queueWrite !== 1'b0) chk(16'(queueCode), 16'(eq.size() ? eq.pop_front() : 4'h0));
        rdPend <= regRead;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        nMismatch++;
        report_and_stop;
    end
    initial begin
        {rst, rowPin, statusClear, lfsr} = {1'b1, 22'h000000, 8'h28};
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 8'h1B; a <= 8'h21; a++) begin
            host.wr(8'(a), 8'hFF);
            rq.push_back(a > 8'h20 ? 9'h000 : {1'b1, a[0] ? gpi_cfg_pkg::MASK_BANK_A : gpi_cfg_pkg::MASK_BANK_B});
            host.rd(8'(a));
            host.wr(8'(a), 8'h00);
        end
        host.wr(gpi_cfg_pkg::OFS_POL_A, 8'h3F);
        host.wr(gpi_cfg_pkg::OFS_POL_B, 8'h1F);
        repeat (5) begin
            lfsr = lfsr_next(lfsr);
            k = lfsr % 11;
            b = (k < 6) ? 0 : 1;
            pos = k - 6 * b;
            host.wr(gpi_cfg_pkg::OFS_IRQ_A + 8'(b), 8'h01 << pos);
            @(posedge mclk) statusClear <= 11'h7FF;
            @(posedge mclk) statusClear <= 11'h000;
            repeat (6) @(posedge mclk);
            chk(16'(irqStatus), 16'h0000);
            rowPin <= 11'h001 << k;
            repeat (8) @(posedge mclk);
            chk(16'({summaryInputIrq, irqStatus}), 16'({1'b1, 11'h001 << k}));
            host.wr(gpi_cfg_pkg::OFS_IRQ_A + 8'(b), 8'h00);
            repeat (3) @(posedge mclk);
            chk(16'(summaryInputIrq), 16'h0000);
            host.wr(gpi_cfg_pkg::OFS_IRQ_A + 8'(b), 8'h01 << pos);
            host.wr(gpi_cfg_pkg::OFS_EVT_A + 8'(b), 8'h01 << pos);
            repeat (3) @(posedge mclk);
            chk(16'(summaryInputIrq), 16'h0000);
            eq.push_back(4'(k + 1));
            rowPin <= 11'h000;
            repeat (8) @(posedge mclk);
            host.wr(gpi_cfg_pkg::OFS_EVT_A + 8'(b), 8'h00);
        end
        chk(16'(eq.size()), 16'h0000);
        report_and_stop;
    end
endmodule : gpi_interrupt_event_config_tb_top
